// [dds_params.svh]
// Purpose: Offsets, field positions, reset values, step sizes and FIFO depth of the distributed DMA slave channel.
// Assumes: Byte-wide I/O access within a 16-byte window.
// Notes: Included by the package and by the channel module.
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

// -----------------------------------------------------------------------------
// Window and register offsets
// -----------------------------------------------------------------------------
`define DDS_CFG_SOCKET_DMA 8'h98
`define DDS_WIN_HI 15
`define DDS_WIN_LO 4
`define DDS_OFF_ADDR_LO 4'h0
`define DDS_OFF_ADDR_HI 4'h1
`define DDS_OFF_PAGE 4'h2
`define DDS_OFF_COUNT_LO 4'h4
`define DDS_OFF_COUNT_HI 4'h5
`define DDS_OFF_COMMAND 4'h8
`define DDS_OFF_STATUS 4'h8
`define DDS_OFF_MODE 4'hb

// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define DDS_CMD_DISABLE_BIT 2
`define DDS_MODE_DIR_BIT 5
`define DDS_ADDR_RESET 16'h0000
`define DDS_PAGE_RESET 8'h00
`define DDS_COUNT_RESET 16'h0000
`define DDS_CMD_RESET 8'h00
`define DDS_STEP_8BIT 16'h0001
`define DDS_STEP_16BIT 16'h0002
`define DDS_FIFO_DEPTH 8

`endif

// [dds_pkg.sv]
// Purpose: Types shared by the distributed DMA slave channel modules.
// Assumes: dds_params.svh supplies the numeric constants.
// Notes: Holds only types.
`include "dds_params.svh"

package dds_pkg;

  typedef enum logic [1:0] {
    DDS_IDLE,
    DDS_ADDR,
    DDS_DATA
  } dds_state_e;

  typedef logic [3:0] dds_off_t;

endpackage

// [dds_fifo.sv]
// Purpose: Small synchronous FIFO for transfer data.
// Assumes: One clock, synchronous active-low reset.
// Notes: Full and empty are exact; storage is flip-flops indexed by pointer.
`timescale 1ns/1ps
`default_nettype none

module dds_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic CLK, // clock
  input wire logic RESET_N, // synchronous reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes data
  output logic [WIDTH-1:0] out_data // head data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] used;
  } dds_fifo_s;

  dds_fifo_s q;
  dds_fifo_s next_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (q.used != (AW+1)'(DEPTH));
  assign out_valid = (q.used != '0);
  assign out_data = q.mem[q.rd];

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.mem[q.wr] = in_data;
      next_q.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      next_q.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      next_q.used = q.used + 1'b1;
    end else if (pop && !push) begin
      next_q.used = q.used - 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// [dds_channel.sv]
// Purpose: Register window and address/count engine of one distributed DMA slave channel.
// Assumes: Host I/O accesses arrive as byte strobes already qualified by the PCI target; PCI clock and reset.
// Notes: Transfer data from the card side passes through an 8-word FIFO.
`include "dds_params.svh"
`timescale 1ns/1ps
`default_nettype none

module dds_channel #(
  parameter int DATA_WIDTH = 16,
  parameter int FIFO_DEPTH = `DDS_FIFO_DEPTH
) (
  input wire logic CLK, // PCI clock
  input wire logic RESET_N, // PCI reset, synchronous, active low
  input wire logic CFG_WR, // config write strobe to socket DMA register
  input wire logic [15:0] CFG_WDATA, // config write data, low half
  output logic [15:0] CFG_RDATA, // socket DMA register readback
  input wire logic IO_WR, // I/O write strobe, one byte
  input wire logic IO_RD, // I/O read strobe, one byte
  input wire logic [15:0] IO_ADDR, // I/O byte address
  input wire logic [7:0] IO_WDATA, // I/O write data
  output logic [7:0] IO_RDATA, // I/O read data, one cycle after strobe
  output logic IO_HIT, // access fell inside the window
  input wire logic XFER_REQ, // card requests a transfer, pin
  input wire logic XFER_16BIT, // 16-bit transfer mode select, pin
  input wire logic [DATA_WIDTH-1:0] XFER_DATA, // data for the transfer
  output logic XFER_READY, // transfer accepted into the FIFO
  output logic ADDR_PHASE, // address phase is on the AD lines
  output logic [23:0] PCI_AD, // address phase value
  output logic TERMINAL_COUNT, // count reached terminal count
  output logic OUT_VALID, // FIFO head valid
  input wire logic OUT_READY, // consumer takes FIFO head
  output logic [DATA_WIDTH-1:0] OUT_DATA // FIFO head data
);
  import dds_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:4] win_base;
    logic [15:0] base_addr;
    logic [15:0] cur_addr;
    logic [7:0] page;
    logic [15:0] base_count;
    logic [15:0] cur_count;
    logic controller_disable_bit;
    logic address_direction;
    logic [3:0] terminal_count;
    logic [1:0] req_sync;
    logic [1:0] mode_sync;
    dds_state_e state;
    logic [7:0] rdata;
    logic hit;
    logic addr_phase;
    logic [23:0] ad;
    logic tc_out;
  } dds_regs_s;

  dds_regs_s q;
  dds_regs_s next_q;
  dds_off_t off;
  logic in_win;
  logic fifo_ready;
  logic fifo_push;
  logic [15:0] step;
  logic tc_set;

  assign in_win = (IO_ADDR[`DDS_WIN_HI:`DDS_WIN_LO] == q.win_base);
  assign off = dds_off_t'(IO_ADDR[3:0]);
  assign step = q.mode_sync[1] ? `DDS_STEP_16BIT : `DDS_STEP_8BIT;
  assign fifo_push = (q.state == DDS_DATA);
  assign tc_set = (q.state == DDS_DATA) && fifo_ready && (q.cur_count <= step);

  // ---------------------------------------------------------------------------
  // Data buffer
  // ---------------------------------------------------------------------------
  dds_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data(XFER_DATA),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(OUT_DATA)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.req_sync = {q.req_sync[0], XFER_REQ};
    next_q.mode_sync = {q.mode_sync[0], XFER_16BIT};
    next_q.hit = 1'b0;
    next_q.addr_phase = 1'b0;
    next_q.tc_out = (q.terminal_count != 4'h0);
    if (CFG_WR) begin
      next_q.win_base = CFG_WDATA[`DDS_WIN_HI:`DDS_WIN_LO];
    end
    // Transfer engine. A new transfer only starts when enabled and space exists.
    case (q.state)
      DDS_IDLE: begin
        if (q.req_sync[1] && !q.controller_disable_bit && fifo_ready) begin
          next_q.state = DDS_ADDR;
        end
      end
      DDS_ADDR: begin
        next_q.addr_phase = 1'b1;
        if (q.mode_sync[1]) begin
          next_q.ad = {q.page[7:1], q.cur_addr, 1'b0};
        end else begin
          next_q.ad = {q.page, q.cur_addr};
        end
        next_q.state = DDS_DATA;
      end
      DDS_DATA: begin
        if (fifo_ready) begin
          next_q.cur_addr = q.address_direction ? q.cur_addr - step : q.cur_addr + step;
          next_q.cur_count = q.cur_count - step;
          if (q.cur_count <= step) begin
            next_q.terminal_count = 4'hf;
            next_q.cur_count = 16'h0000;
          end
          next_q.state = DDS_IDLE;
        end
      end
      default: begin
        next_q.state = DDS_IDLE;
      end
    endcase
    // Register reads; reserved locations and legacy bits read as zero.
    next_q.rdata = 8'h00;
    if (IO_RD && in_win) begin
      next_q.hit = 1'b1;
      case (off)
        `DDS_OFF_ADDR_LO: next_q.rdata = q.cur_addr[7:0];
        `DDS_OFF_ADDR_HI: next_q.rdata = q.cur_addr[15:8];
        `DDS_OFF_PAGE: next_q.rdata = q.page;
        `DDS_OFF_COUNT_LO: next_q.rdata = q.cur_count[7:0];
        `DDS_OFF_COUNT_HI: next_q.rdata = q.cur_count[15:8];
        `DDS_OFF_STATUS: begin
          next_q.rdata = {4'h0, q.terminal_count};
          // A terminal count arriving in this same cycle survives the clear.
          if (!tc_set) begin
            next_q.terminal_count = 4'h0;
          end
        end
        `DDS_OFF_MODE: next_q.rdata = {2'b00, q.address_direction, 5'h00};
        default: next_q.rdata = 8'h00;
      endcase
    end
    // Register writes; command bits other than the disable bit are not stored.
    if (IO_WR && in_win) begin
      next_q.hit = 1'b1;
      case (off)
        `DDS_OFF_ADDR_LO: begin
          next_q.base_addr[7:0] = IO_WDATA;
          next_q.cur_addr[7:0] = IO_WDATA;
        end
        `DDS_OFF_ADDR_HI: begin
          next_q.base_addr[15:8] = IO_WDATA;
          next_q.cur_addr[15:8] = IO_WDATA;
        end
        `DDS_OFF_PAGE: next_q.page = IO_WDATA;
        `DDS_OFF_COUNT_LO: begin
          next_q.base_count[7:0] = IO_WDATA;
          next_q.cur_count[7:0] = IO_WDATA;
        end
        `DDS_OFF_COUNT_HI: begin
          next_q.base_count[15:8] = IO_WDATA;
          next_q.cur_count[15:8] = IO_WDATA;
        end
        `DDS_OFF_COMMAND: next_q.controller_disable_bit = IO_WDATA[`DDS_CMD_DISABLE_BIT];
        `DDS_OFF_MODE: next_q.address_direction = IO_WDATA[`DDS_MODE_DIR_BIT];
        default: next_q.hit = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      q <= '0;
      q.base_addr <= `DDS_ADDR_RESET;
      q.cur_addr <= `DDS_ADDR_RESET;
      q.page <= `DDS_PAGE_RESET;
      q.base_count <= `DDS_COUNT_RESET;
      q.cur_count <= `DDS_COUNT_RESET;
      q.controller_disable_bit <= 1'b0;
      q.state <= DDS_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign CFG_RDATA = {q.win_base, 4'h0};
  assign IO_RDATA = q.rdata;
  assign IO_HIT = q.hit;
  assign ADDR_PHASE = q.addr_phase;
  assign PCI_AD = q.ad;
  assign TERMINAL_COUNT = q.tc_out;
  assign XFER_READY = fifo_push && fifo_ready;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_addr_state;
    q.state == DDS_ADDR;
  endsequence

  property p_ad8;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_ADDR && !q.mode_sync[1] |=> PCI_AD == {$past(q.page), $past(q.cur_addr)};
  endproperty
  a_ad8: assert property (p_ad8) else $error("8-bit address phase value wrong.");

  property p_ad16;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_ADDR && q.mode_sync[1] |=> PCI_AD[0] == 1'b0 && PCI_AD[16:1] == $past(q.cur_addr);
  endproperty
  a_ad16: assert property (p_ad16) else $error("16-bit address phase value wrong.");

  property p_no_start;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_IDLE && q.controller_disable_bit |=> q.state == DDS_IDLE;
  endproperty
  a_no_start: assert property (p_no_start) else $error("Transfer started while disabled.");

  property p_count_step;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_DATA && fifo_ready && !IO_WR && q.cur_count > step |=>
      q.cur_count == $past(q.cur_count) - $past(step);
  endproperty
  a_count_step: assert property (p_count_step) else $error("Count step wrong.");

  property p_dir;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_DATA && fifo_ready && !IO_WR && !q.address_direction |=>
      q.cur_addr == $past(q.cur_addr) + $past(step);
  endproperty
  a_dir: assert property (p_dir) else $error("Address did not step up.");

  property p_tc_set;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_DATA && fifo_ready && q.cur_count <= step |=> q.terminal_count == 4'hf ##1 TERMINAL_COUNT;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("Terminal count not flagged.");

  property p_cmd_read;
    @(posedge CLK) disable iff (!RESET_N)
    IO_RD && in_win && off == `DDS_OFF_COMMAND |=> IO_RDATA[7:4] == 4'h0 && IO_HIT;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("Reserved bits read non-zero.");

  property p_rsvd;
    @(posedge CLK) disable iff (!RESET_N)
    IO_RD && in_win && off == 4'h3 |=> IO_RDATA == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved location read non-zero.");

  sequence s_start_cond;
    q.state == DDS_IDLE && q.req_sync[1] && !q.controller_disable_bit && fifo_ready;
  endsequence

  sequence s_addr_then_data;
    s_addr_state ##1 (q.state == DDS_DATA && ADDR_PHASE);
  endsequence

  property p_start;
    @(posedge CLK) disable iff (!RESET_N)
    s_start_cond |=> s_addr_then_data;
  endproperty
  a_start: assert property (p_start) else $error("Transfer skipped its address phase.");

  property p_dir_down;
    @(posedge CLK) disable iff (!RESET_N)
    q.state == DDS_DATA && fifo_ready && !IO_WR && q.address_direction |=>
      q.cur_addr == $past(q.cur_addr) - $past(step);
  endproperty
  a_dir_down: assert property (p_dir_down) else $error("Address did not step down.");

  property p_hold_disabled;
    @(posedge CLK) disable iff (!RESET_N)
    q.controller_disable_bit && q.state != DDS_DATA && !IO_WR |=>
      $stable(q.cur_addr) && $stable(q.cur_count);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("Address or count moved while disabled.");

  property p_rsvd_write;
    @(posedge CLK) disable iff (!RESET_N)
    IO_WR && in_win && off inside {4'h3, 4'h6, 4'h7, 4'ha, 4'hc, 4'he} |=>
      $stable(q.base_addr) && $stable(q.base_count) && $stable(q.page) && $stable(q.address_direction);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) else $error("Reserved write changed a register.");

  property p_mode_read;
    @(posedge CLK) disable iff (!RESET_N)
    IO_RD && in_win && off == `DDS_OFF_MODE |=> IO_RDATA[7:6] == 2'b00 && IO_RDATA[4:0] == 5'h00;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("Unused mode bits read non-zero.");

  property p_addr_write;
    @(posedge CLK) disable iff (!RESET_N)
    IO_WR && in_win && off == `DDS_OFF_ADDR_LO |=>
      q.base_addr[7:0] == $past(IO_WDATA) && q.cur_addr[7:0] == $past(IO_WDATA);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("Address write did not land.");

  property p_count_write;
    @(posedge CLK) disable iff (!RESET_N)
    IO_WR && in_win && off == `DDS_OFF_COUNT_HI |=>
      q.base_count[15:8] == $past(IO_WDATA) && q.cur_count[15:8] == $past(IO_WDATA);
  endproperty
  a_count_write: assert property (p_count_write) else $error("Count write did not land.");

  property p_cmd_write;
    @(posedge CLK) disable iff (!RESET_N)
    IO_WR && in_win && off == `DDS_OFF_COMMAND |=>
      q.controller_disable_bit == $past(IO_WDATA[`DDS_CMD_DISABLE_BIT]);
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("Disable bit write did not land.");

  property p_out_win;
    @(posedge CLK) disable iff (!RESET_N)
    (IO_RD || IO_WR) && !in_win |=> !IO_HIT;
  endproperty
  a_out_win: assert property (p_out_win) else $error("Access outside the window was claimed.");

  property p_tc_clear;
    @(posedge CLK) disable iff (!RESET_N)
    IO_RD && in_win && off == `DDS_OFF_STATUS && !tc_set |=> q.terminal_count == 4'h0;
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("Status read did not clear terminal count.");

endmodule
`default_nettype wire

// [dds_card_model.sv]
// Purpose: Card-side partner of the DMA slave channel: request pin, mode pin, data and drain side.
// Assumes: The bench drives run, m16 and stall at rising edges.
// Notes: Offered data counts up from 16'h1000, one step per accepted word.
`timescale 1ns/1ps
`default_nettype none

module dds_card (
  input wire logic CLK, // clock
  input wire logic RESET_N, // reset, active low
  input wire logic run, // keep requesting
  input wire logic m16, // 16-bit mode
  input wire logic stall, // drain side stalls
  input wire logic ADDR_PHASE, // address phase seen
  input wire logic XFER_READY, // word taken
  output logic XFER_REQ, // request pin
  output logic XFER_16BIT, // mode pin
  output logic [15:0] XFER_DATA, // word offered
  output logic OUT_READY // drain side ready
);
  // ---------------------------------------------------------------------------
  // Request handshake
  // ---------------------------------------------------------------------------
  logic pend;

  // A started transfer keeps its request and data until the word is taken.
  assign XFER_REQ = run | pend;
  assign XFER_16BIT = m16;
  assign OUT_READY = !stall;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pend <= 1'b0;
      XFER_DATA <= 16'h1000;
    end else begin
      if (ADDR_PHASE) begin
        pend <= 1'b1;
      end
      if (XFER_READY) begin
        pend <= 1'b0;
        XFER_DATA <= XFER_DATA + 16'h0001;
      end
    end
  end
endmodule

`default_nettype wire

// [dds_tb.sv]
// Purpose: Self-checking bench for the DMA slave channel.
// Assumes: Byte accesses, one read answer a cycle after the strobe.
// Notes: Expected address, count and data are tracked from observed handshakes.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  localparam logic [15:0] BASE = 16'h1230;
  logic CLK = 1'b0, RESET_N = 1'b0, CFG_WR = 1'b0, IO_WR = 1'b0, IO_RD = 1'b0;
  logic [15:0] CFG_WDATA = 16'h0000, IO_ADDR = 16'h0000, win = 16'h0000;
  logic [7:0] IO_WDATA = 8'h00, IO_RDATA, exp_page = 8'h00;
  logic run = 1'b0, m16 = 1'b0, stall = 1'b0, hit_e = 1'b1, exp_tc = 1'b0, down = 1'b0;
  logic IO_HIT, XFER_REQ, XFER_16BIT, XFER_READY, ADDR_PHASE, TERMINAL_COUNT, OUT_VALID, OUT_READY;
  logic [15:0] CFG_RDATA, XFER_DATA, OUT_DATA, step, exp_addr = 16'h0000, exp_cnt = 16'h0000;
  logic [15:0] exp_data = 16'h1000;
  logic [23:0] PCI_AD, exp_ad;
  logic [3:0] rsv [6] = '{4'h3, 4'h6, 4'h7, 4'ha, 4'hc, 4'he};
  int failures = 0, n_tests = 0, cycles = 0, pushes = 0, total = 0;

  dds_channel #(.DATA_WIDTH(16), .FIFO_DEPTH(8)) dut_u (.CLK(CLK), .RESET_N(RESET_N), .CFG_WR(CFG_WR),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_ADDR(IO_ADDR),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_HIT(IO_HIT), .XFER_REQ(XFER_REQ),
    .XFER_16BIT(XFER_16BIT), .XFER_DATA(XFER_DATA), .XFER_READY(XFER_READY), .ADDR_PHASE(ADDR_PHASE),
    .PCI_AD(PCI_AD), .TERMINAL_COUNT(TERMINAL_COUNT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_DATA(OUT_DATA));

  dds_card card_u (.CLK(CLK), .RESET_N(RESET_N), .run(run), .m16(m16), .stall(stall),
    .ADDR_PHASE(ADDR_PHASE), .XFER_READY(XFER_READY), .XFER_REQ(XFER_REQ), .XFER_16BIT(XFER_16BIT),
    .XFER_DATA(XFER_DATA), .OUT_READY(OUT_READY));

  always #10 CLK = ~CLK;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic io_wr(input logic [3:0] off, input logic [7:0] d);
    IO_WR <= 1'b1;
    IO_ADDR <= {win[15:4], off};
    IO_WDATA <= d;
    @(posedge CLK);
    IO_WR <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd_chk(input logic [3:0] off, input logic [7:0] e);
    IO_RD <= 1'b1;
    IO_ADDR <= {win[15:4], off};
    @(posedge CLK);
    IO_RD <= 1'b0;
    #1;
    check({15'h0000, IO_HIT, IO_RDATA}, {15'h0000, hit_e, e});
    @(posedge CLK);
  endtask

  task automatic rd16(input logic [3:0] off, input logic [15:0] e);
    rd_chk(off, e[7:0]);
    rd_chk(off + 4'h1, e[15:8]);
  endtask

  // ---------------------------------------------------------------------------
  // Transfer monitor and timeout
  // ---------------------------------------------------------------------------
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
    if (RESET_N && ADDR_PHASE) begin
      exp_ad = m16 ? {exp_page[7:1], exp_addr, 1'b0} : {exp_page, exp_addr};
      check(PCI_AD, exp_ad);
    end
    if (RESET_N && XFER_READY) begin
      step = m16 ? 16'h0002 : 16'h0001;
      pushes++;
      total++;
      exp_addr = down ? exp_addr - step : exp_addr + step;
      if (exp_cnt <= step) begin
        exp_cnt = 16'h0000;
        exp_tc = 1'b1;
      end else begin
        exp_cnt = exp_cnt - step;
      end
    end
    if (RESET_N && OUT_VALID && OUT_READY) begin
      check({8'h00, OUT_DATA}, {8'h00, exp_data});
      exp_data = exp_data + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 16; i++) rd_chk(i[3:0], 8'h00);
    CFG_WR <= 1'b1;
    CFG_WDATA <= BASE;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    @(posedge CLK);
    check({8'h00, CFG_RDATA}, {8'h00, BASE});
    hit_e = 1'b0;
    io_wr(4'h2, 8'h5a);
    rd_chk(4'h2, 8'h00);
    win = BASE;
    hit_e = 1'b1;
    rd_chk(4'h2, 8'h00);
    io_wr(4'h0, 8'hfe);
    io_wr(4'h1, 8'h12);
    io_wr(4'h2, 8'ha5);
    io_wr(4'h4, 8'h05);
    io_wr(4'h5, 8'h00);
    exp_addr = 16'h12fe;
    exp_page = 8'ha5;
    exp_cnt = 16'h0005;
    foreach (rsv[k]) begin
      io_wr(rsv[k], 8'hff);
      rd_chk(rsv[k], 8'h00);
    end
    rd16(4'h0, exp_addr);
    rd_chk(4'h2, exp_page);
    rd16(4'h4, exp_cnt);
    // Disabled controller: the request stays up but nothing may move.
    io_wr(4'h8, 8'hff);
    run <= 1'b1;
    repeat (40) @(posedge CLK);
    check(pushes[23:0], 24'h000000);
    rd16(4'h0, exp_addr);
    rd16(4'h4, exp_cnt);
    io_wr(4'h8, 8'h00);
    repeat (40) @(posedge CLK);
    run <= 1'b0;
    repeat (20) @(posedge CLK);
    rd16(4'h0, exp_addr);
    rd16(4'h4, exp_cnt);
    check({23'h000000, TERMINAL_COUNT}, {23'h000000, exp_tc});
    rd_chk(4'h8, 8'h0f);
    rd_chk(4'h8, 8'h00);
    exp_tc = 1'b0;
    repeat (2) @(posedge CLK);
    check({23'h000000, TERMINAL_COUNT}, 24'h000000);
    // 16-bit, downward, with the drain stalled until the FIFO refuses.
    io_wr(4'hb, 8'h20);
    rd_chk(4'hb, 8'h20);
    down = 1'b1;
    io_wr(4'h0, 8'h10);
    io_wr(4'h1, 8'h00);
    io_wr(4'h2, 8'h7b);
    io_wr(4'h4, 8'h40);
    io_wr(4'h5, 8'h00);
    exp_addr = 16'h0010;
    exp_page = 8'h7b;
    exp_cnt = 16'h0040;
    pushes = 0;
    m16 <= 1'b1;
    stall <= 1'b1;
    repeat (4) @(posedge CLK);
    run <= 1'b1;
    repeat (100) @(posedge CLK);
    check(pushes[23:0], 24'h000008);
    run <= 1'b0;
    repeat (10) @(posedge CLK);
    stall <= 1'b0;
    repeat (40) @(posedge CLK);
    check({23'h000000, OUT_VALID}, 24'h000000);
    check({8'h00, exp_data - 16'h1000}, total[23:0]);
    rd16(4'h0, exp_addr);
    rd16(4'h4, exp_cnt);
    end_of_test();
  end
endmodule

`default_nettype wire
